// file: bench/adcrs_conv_model.sv
// Conversion engine model: delivers one finished result on request.
// Assumes requests arrive one at a time and are applied after the falling edge.
`timescale 1ns/1ns
module adcrs_conv_model
(
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        go_in,
  input  wire logic [2:0]  chan_in,
  input  wire logic [15:0] data_in,
  input  wire logic [3:0]  delay_in,
  output logic             conv_done_out,
  output logic      [2:0]  conv_chan_out,
  output logic      [15:0] conv_data_out
);
  logic       busy;
  logic [3:0] cnt;
  //////////////////////////////////////////////////////////////////////
  // Word lines toggle outside the done cycle so stale data never looks valid
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      busy          <= 1'b0;
      cnt           <= 4'h0;
      conv_done_out <= 1'b0;
      conv_chan_out <= 3'h0;
      conv_data_out <= 16'h5a5a;
    end
    else
    begin
      conv_done_out <= 1'b0;
      conv_data_out <= ~conv_data_out;
      conv_chan_out <= ~conv_chan_out;
      if (go_in)
      begin
        busy <= 1'b1;
        cnt  <= delay_in;
      end
      else if (busy && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (busy)
      begin
        busy          <= 1'b0;
        conv_done_out <= 1'b1;
        conv_chan_out <= chan_in;
        conv_data_out <= data_in;
      end
    end
  end
endmodule

// file: bench/tb_adc_comparator_channel_and_results.sv
// Testbench: channel select register, result reads, anti-tear and alarms.
// Assumes the register port and conversion model are driven at the falling edge.
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module tb_adc_comparator_channel_and_results;
  logic        ref_clk_in, nrst_in, reg_wr_in, reg_rd_in, go, done, pol2, pol3, al2, al3;
  logic [7:0]  reg_addr_in, reg_wdata_in, rdata, d;
  logic [2:0]  src2, src3, gch, cch;
  logic [15:0] gdat, cdat, thr2, thr3;
  logic [3:0]  gdly;
  int          bad_count, compares;
  //////////////////////////////////////////////////////////////////////
  adcrs_conv_model model (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .go_in(go),
    .chan_in(gch), .data_in(gdat), .delay_in(gdly), .conv_done_out(done),
    .conv_chan_out(cch), .conv_data_out(cdat));
  adcrs_top dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .conv_done_in(done), .conv_chan_in(cch), .conv_data_in(cdat),
    .comp2_threshold_in(thr2), .comp2_polarity_in(pol2), .comp3_threshold_in(thr3),
    .comp3_polarity_in(pol3), .second_comparator_source_out(src2),
    .third_comparator_source_out(src3), .comp2_alarm_out(al2), .comp3_alarm_out(al3));
  //////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk_in);
    reg_addr_in = a; reg_wdata_in = v; reg_wr_in = 1'b1;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk_in);
    reg_addr_in = a; reg_rd_in = 1'b1;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0; v = rdata;
  endtask
  // Runs one conversion; returns the alarm pulses seen one cycle after it lands
  task automatic conv(input logic [2:0] c, input logic [15:0] w, output logic a2,
                      output logic a3);
    int n;
    @(negedge ref_clk_in);
    go = 1'b1; gch = c; gdat = w; gdly = {2'b00, c[1:0]};
    @(negedge ref_clk_in);
    go = 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++)
      @(negedge ref_clk_in);
    if (n == 20)
      `CHK(done, 1'b1)
    @(negedge ref_clk_in);
    a2 = al2; a3 = al3;
    @(negedge ref_clk_in);
    `CHK({al2, al3}, 2'b00)
  endtask
  function automatic logic [7:0] hi_addr(input logic [2:0] c);
    case (c)
      3'h1: return 8'h48;
      3'h2: return 8'h44;
      3'h3: return 8'h42;
      3'h4: return 8'h46;
      3'h5: return 8'h4a;
      default: return 8'h4c;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK(src2, 3'h2)
    `CHK(src3, 3'h0)
    rd(8'h41, d);
    `CHK(d, 8'h40)
  endtask
  task automatic t_select();
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = {i[2:0], 3'(7 - i), i[1:0]};
      wr(8'h41, v);
      `CHK(src2, i[2:0])
      `CHK(src3, 3'(7 - i))
      rd(8'h41, d);
      `CHK(d, v)
    end
  endtask
  task automatic t_results();
    logic [15:0] w;
    logic        a2, a3;
    for (int c = 1; c < 7; c++)
    begin
      w = {4'ha, 1'b0, c[2:0], 4'h3, 1'b1, c[2:0]};
      conv(c[2:0], w, a2, a3);
      wr(hi_addr(c[2:0]), 8'hff);
      rd(hi_addr(c[2:0]), d);
      `CHK(d, w[15:8])
      rd(hi_addr(c[2:0]) + 8'h01, d);
      `CHK(d, w[7:0])
    end
    rd(8'h50, d);
    `CHK(d, 8'h00)
  endtask
  task automatic t_tear();
    logic a2, a3;
    conv(3'h3, 16'h1234, a2, a3);
    rd(8'h42, d);
    `CHK(d, 8'h12)
    conv(3'h3, 16'hbeef, a2, a3);
    rd(8'h43, d);
    `CHK(d, 8'h34)
    rd(8'h42, d);
    `CHK(d, 8'hbe)
  endtask
  task automatic t_alarm(input logic [2:0] c, input logic [15:0] w, input logic p2,
                         input logic p3, input logic [1:0] e);
    logic a2, a3;
    pol2 = p2; pol3 = p3;
    conv(c, w, a2, a3);
    `CHK({a2, a3}, e)
  endtask
  // Read and write in one cycle, then back-to-back reads of one result pair
  task automatic t_b2b();
    logic [7:0] hi;
    @(negedge ref_clk_in);
    reg_addr_in = 8'h41; reg_wdata_in = 8'h6f; reg_wr_in = 1'b1; reg_rd_in = 1'b1;
    @(negedge ref_clk_in);
    `CHK(rdata, 8'he3)
    reg_wr_in = 1'b0;
    @(negedge ref_clk_in);
    `CHK(rdata, 8'h6f)
    `CHK(src2, 3'h3)
    `CHK(src3, 3'h3)
    reg_addr_in = 8'h42;
    @(negedge ref_clk_in);
    hi = rdata;
    reg_addr_in = 8'h43;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    `CHK({hi, rdata}, 16'hbeef)
  endtask
  // Reset in mid-run restores the select register and clears read data
  task automatic t_midreset();
    @(negedge ref_clk_in);
    nrst_in = 1'b0;
    @(negedge ref_clk_in);
    `CHK(rdata, 8'h00)
    nrst_in = 1'b1;
    t_reset();
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial
  begin
    bad_count = 0; compares = 0; nrst_in = 1'b0; reg_wr_in = 1'b0; reg_rd_in = 1'b0;
    reg_addr_in = 8'h00; reg_wdata_in = 8'h00; go = 1'b0; gch = 3'h0; gdat = 16'h0000;
    gdly = 4'h0; thr2 = 16'h1000; thr3 = 16'h1000; pol2 = 1'b0; pol3 = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    nrst_in = 1'b1;
    t_reset();
    t_select();
    t_results();
    t_tear();
    t_b2b();
    wr(8'h41, 8'h4c);
    t_alarm(3'h2, 16'h0fff, 1'b0, 1'b0, 2'b10);
    t_alarm(3'h2, 16'h1000, 1'b0, 1'b0, 2'b00);
    t_alarm(3'h2, 16'h1001, 1'b1, 1'b0, 2'b10);
    t_alarm(3'h2, 16'h0fff, 1'b1, 1'b0, 2'b00);
    t_alarm(3'h3, 16'h0800, 1'b0, 1'b0, 2'b01);
    t_alarm(3'h3, 16'h2000, 1'b0, 1'b1, 2'b01);
    wr(8'h41, 8'he0);
    t_alarm(3'h7, 16'h0fff, 1'b0, 1'b0, 2'b10);
    t_midreset();
    print_verdict();
  end
endmodule

// file: core/adcrs_pkg.sv
// Package: register map, field layout, reset values and channel codes
// for the converter comparator-channel and result register block.
// Assumes an 8-bit register address space reached by the serial link engine.
package adcrs_pkg;

  typedef logic [2:0] adcrs_chan_t;

  localparam int RESULT_W = 16;

  // Register addresses
  localparam logic [7:0] ADDR_COMP_SEL = 8'h41;
  localparam logic [7:0] ADDR_VBAT_HI  = 8'h42;
  localparam logic [7:0] ADDR_VBAT_LO  = 8'h43;
  localparam logic [7:0] ADDR_THERM_HI = 8'h44;
  localparam logic [7:0] ADDR_THERM_LO = 8'h45;
  localparam logic [7:0] ADDR_ICHG_HI  = 8'h46;
  localparam logic [7:0] ADDR_ICHG_LO  = 8'h47;
  localparam logic [7:0] ADDR_AUX_HI   = 8'h48;
  localparam logic [7:0] ADDR_AUX_LO   = 8'h49;
  localparam logic [7:0] ADDR_SUPPLY_HI = 8'h4A;
  localparam logic [7:0] ADDR_SUPPLY_LO = 8'h4B;
  localparam logic [7:0] ADDR_RAIL_HI  = 8'h4C;
  localparam logic [7:0] ADDR_RAIL_LO  = 8'h4D;

  // Channel select register layout and reset
  localparam logic [7:0] COMP_SEL_RESET = 8'h40;
  localparam int         COMP2_MSB      = 7;
  localparam int         COMP2_LSB      = 5;
  localparam int         COMP3_MSB      = 4;
  localparam int         COMP3_LSB      = 2;
  localparam int         RSVD_MSB       = 1;
  localparam int         RSVD_LSB       = 0;

  // Channel codes
  localparam adcrs_chan_t CH_OFF  = 3'h0;
  localparam adcrs_chan_t CH_AUX  = 3'h1;
  localparam adcrs_chan_t CH_THERM = 3'h2;
  localparam adcrs_chan_t CH_VBAT = 3'h3;
  localparam adcrs_chan_t CH_ICHG = 3'h4;
  localparam adcrs_chan_t CH_SUPPLY = 3'h5;
  localparam adcrs_chan_t CH_RAIL   = 3'h6;
  localparam adcrs_chan_t CH_INCUR  = 3'h7;

  localparam logic [7:0] READ_IDLE = 8'h00;

endpackage

// file: core/adcrs_result_store.sv
// Result store: one whole 16-bit word per channel, written atomically.
// Assumes writes come only from completed conversions; contents have no reset.
`timescale 1ns/1ns
module adcrs_result_store
(
  input  wire logic    ref_clk_in,
  input  wire logic    nrst_in,
  adcrs_store_if.store st
);

  logic [adcrs_pkg::RESULT_W-1:0] mem [0:7];

  // Whole word written in one edge
  always_ff @(posedge ref_clk_in)
  begin
    if (st.wr_en)
    begin
      mem[st.wr_chan] <= st.wr_data;
    end
  end

  assign st.rd_word = mem[st.rd_chan];

  ////////////////////////////////////////////////////////////////////////////
  a_store_write_lands: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    st.wr_en ##1 (st.rd_chan == $past(st.wr_chan)) |-> st.rd_word == $past(st.wr_data))
    else $error("Stored word differs from the written conversion");

endmodule

// file: core/adcrs_store_if.sv
// Interface: write and read paths between the register logic and the result store.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface adcrs_store_if;
  logic                         wr_en;
  adcrs_pkg::adcrs_chan_t       wr_chan;
  logic [adcrs_pkg::RESULT_W-1:0] wr_data;
  adcrs_pkg::adcrs_chan_t       rd_chan;
  logic [adcrs_pkg::RESULT_W-1:0] rd_word;

  modport owner (output wr_en, wr_chan, wr_data, rd_chan, input rd_word);
  modport store (input wr_en, wr_chan, wr_data, rd_chan, output rd_word);
endinterface

// file: core/adcrs_top.sv
// Comparator channel select register and 16-bit result registers.
// Assumes the serial link engine issues one-cycle byte reads and writes,
// and the conversion engine pulses conv_done_in with a whole result.
// Overview of operation
// - Bits 7-5 pick the second comparator's channel; reset to thermistor.
// - Bits 4-2 pick the third comparator's channel, same codes; reset to off.
// - Battery voltage result reads at 0x42 high and 0x43 low.
// - Thermistor result reads at 0x44 high and 0x45 low.
// - Charge current result reads at 0x46 high and 0x47 low.
// - Auxiliary input result reads at 0x48 high and 0x49 low.
// - Supply input voltage result reads at 0x4A high and 0x4B low.
// - Bits 1-0 are plain storage, reset 00, with no effect.
// - Polarity 0 flags below threshold, polarity 1 flags above.
// - System rail result reads at 0x4C high and 0x4D low.
`timescale 1ns/1ns
module adcrs_top
#(
  parameter int RESULT_W = adcrs_pkg::RESULT_W
)
(
  input  wire logic                ref_clk_in,
  input  wire logic                nrst_in,
  input  wire logic [7:0]          reg_addr_in,
  input  wire logic                reg_wr_in,
  input  wire logic [7:0]          reg_wdata_in,
  input  wire logic                reg_rd_in,
  output logic      [7:0]          reg_rdata_out,
  input  wire logic                conv_done_in,
  input  wire logic [2:0]          conv_chan_in,
  input  wire logic [RESULT_W-1:0] conv_data_in,
  input  wire logic [RESULT_W-1:0] comp2_threshold_in,
  input  wire logic                comp2_polarity_in,
  input  wire logic [RESULT_W-1:0] comp3_threshold_in,
  input  wire logic                comp3_polarity_in,
  output logic      [2:0]          second_comparator_source_out,
  output logic      [2:0]          third_comparator_source_out,
  output logic                     comp2_alarm_out,
  output logic                     comp3_alarm_out
);

  logic [7:0]             comp_sel;
  logic [7:0]             next_rdata;
  logic                   shadow_valid;
  adcrs_pkg::adcrs_chan_t shadow_chan;
  logic [7:0]             shadow_low;
  adcrs_pkg::adcrs_chan_t rd_ch;
  logic                   sel_hit;

  adcrs_store_if st ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic adcrs_pkg::adcrs_chan_t addr_to_chan(input logic [7:0] a);
    logic [6:0] pair;
    pair = a[7:1];
    if (pair == adcrs_pkg::ADDR_VBAT_HI[7:1])
      return adcrs_pkg::CH_VBAT;
    else if (pair == adcrs_pkg::ADDR_THERM_HI[7:1])
      return adcrs_pkg::CH_THERM;
    else if (pair == adcrs_pkg::ADDR_ICHG_HI[7:1])
      return adcrs_pkg::CH_ICHG;
    else if (pair == adcrs_pkg::ADDR_AUX_HI[7:1])
      return adcrs_pkg::CH_AUX;
    else if (pair == adcrs_pkg::ADDR_SUPPLY_HI[7:1])
      return adcrs_pkg::CH_SUPPLY;
    else if (pair == adcrs_pkg::ADDR_RAIL_HI[7:1])
      return adcrs_pkg::CH_RAIL;
    else
      return adcrs_pkg::CH_OFF;
  endfunction

  // Threshold comparison by polarity
  function automatic logic cmp_hit(input logic [RESULT_W-1:0] d,
                                   input logic [RESULT_W-1:0] thr,
                                   input logic                above);
    return above ? (d > thr) : (d < thr);
  endfunction

  assign rd_ch   = addr_to_chan(reg_addr_in);
  assign sel_hit = (reg_addr_in == adcrs_pkg::ADDR_COMP_SEL);

  ////////////////////////////////////////////////////////////////////////////
  // Result store
  assign st.wr_en   = conv_done_in && (conv_chan_in != adcrs_pkg::CH_OFF)
                      && (conv_chan_in != adcrs_pkg::CH_INCUR);
  assign st.wr_chan = conv_chan_in;
  assign st.wr_data = conv_data_in;
  assign st.rd_chan = rd_ch;

  adcrs_result_store u_store
  (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .st         (st)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel select register
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      comp_sel <= adcrs_pkg::COMP_SEL_RESET;
    end
    else if (reg_wr_in && sel_hit)
    begin
      comp_sel <= reg_wdata_in;
    end
  end

  assign second_comparator_source_out =
    comp_sel[adcrs_pkg::COMP2_MSB:adcrs_pkg::COMP2_LSB];
  assign third_comparator_source_out  =
    comp_sel[adcrs_pkg::COMP3_MSB:adcrs_pkg::COMP3_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Low-byte snapshot taken with each high-byte read
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      shadow_valid <= 1'b0;
      shadow_chan  <= adcrs_pkg::CH_OFF;
      shadow_low   <= 8'h00;
    end
    else if (reg_rd_in && (rd_ch != adcrs_pkg::CH_OFF))
    begin
      if (!reg_addr_in[0])
      begin
        shadow_valid <= 1'b1;
        shadow_chan  <= rd_ch;
        shadow_low   <= st.rd_word[7:0];
      end
      else
      begin
        shadow_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb
  begin
    next_rdata = adcrs_pkg::READ_IDLE;
    if (sel_hit)
    begin
      next_rdata = comp_sel;
    end
    else if (rd_ch != adcrs_pkg::CH_OFF)
    begin
      if (!reg_addr_in[0])
        next_rdata = st.rd_word[RESULT_W-1:8];
      else if (shadow_valid && (shadow_chan == rd_ch))
        next_rdata = shadow_low;
      else
        next_rdata = st.rd_word[7:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reg_rdata_out <= adcrs_pkg::READ_IDLE;
    end
    else if (reg_rd_in)
    begin
      reg_rdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator alarms
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      comp2_alarm_out <= 1'b0;
    end
    else
    begin
      comp2_alarm_out <= conv_done_in && (second_comparator_source_out != adcrs_pkg::CH_OFF)
        && (conv_chan_in == second_comparator_source_out)
        && cmp_hit(conv_data_in, comp2_threshold_in, comp2_polarity_in);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      comp3_alarm_out <= 1'b0;
    end
    else
    begin
      comp3_alarm_out <= conv_done_in && (third_comparator_source_out != adcrs_pkg::CH_OFF)
        && (conv_chan_in == third_comparator_source_out)
        && cmp_hit(conv_data_in, comp3_threshold_in, comp3_polarity_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_hi_read;
    reg_rd_in && (rd_ch != adcrs_pkg::CH_OFF) && !reg_addr_in[0];
  endsequence

  sequence s_lo_read_same;
    reg_rd_in && reg_addr_in[0] && (rd_ch == $past(rd_ch));
  endsequence

  property p_no_tear;
    logic [7:0] lo;
    (s_hi_read, lo = st.rd_word[7:0]) ##1 s_lo_read_same |=> reg_rdata_out == lo;
  endproperty

  a_reset_sel_value: assert property ($rose(nrst_in) |-> comp_sel == 8'h40)
    else $error("Channel select not at reset value after release");

  a_comp2_field_write: assert property (reg_wr_in && sel_hit |=>
    second_comparator_source_out == $past(reg_wdata_in[7:5]))
    else $error("Second comparator source not taken from bits 7-5");

  a_comp3_field_write: assert property (reg_wr_in && sel_hit |=>
    third_comparator_source_out == $past(reg_wdata_in[4:2]))
    else $error("Third comparator source not taken from bits 4-2");

  a_reserved_readback: assert property (reg_wr_in && sel_hit ##1
    (reg_rd_in && sel_hit && !reg_wr_in) |=> reg_rdata_out[1:0] == $past(reg_wdata_in[1:0], 2))
    else $error("Reserved bits did not read back as written");

  a_result_high_read: assert property (s_hi_read |=>
    reg_rdata_out == $past(st.rd_word[15:8]))
    else $error("High result byte differs from stored word");

  a_low_no_tear: assert property (p_no_tear)
    else $error("Low byte not from the same conversion as high byte");

  a_unmapped_zero: assert property (reg_rd_in && !sel_hit && (rd_ch == adcrs_pkg::CH_OFF)
    |=> reg_rdata_out == 8'h00)
    else $error("Unmapped address did not read zero");

  a_comp3_off_quiet: assert property ((third_comparator_source_out == 3'h0) |=>
    !comp3_alarm_out)
    else $error("Disabled third comparator raised an alarm");

  a_comp2_below_flag: assert property (conv_done_in && !comp2_polarity_in
    && (second_comparator_source_out != 3'h0)
    && (conv_chan_in == second_comparator_source_out)
    && (conv_data_in < comp2_threshold_in) |=> comp2_alarm_out)
    else $error("Below-threshold alarm missed");

  a_comp3_above_flag: assert property (conv_done_in && comp3_polarity_in
    && (conv_chan_in == third_comparator_source_out)
    && (conv_data_in <= comp3_threshold_in) |=> !comp3_alarm_out)
    else $error("Above-threshold alarm raised without exceeding");

endmodule
